// ==== logic/tis_pkg.sv ====
package tis_pkg;
   localparam int WORD_W = 12;
   typedef logic [WORD_W-1:0] tis_word_t;

   // ----------------------------------------
   // Instruction bit positions, bit 00 is msb
   // ----------------------------------------
   localparam int B03 = 8;
   localparam int B04 = 7;
   localparam int B05 = 6;
   localparam int B06 = 5;
   localparam int B07 = 4;
   localparam int OPC_HI = 11;
   localparam int OPC_LO = 9;
   localparam int PAGE_HI = 11;
   localparam int PAGE_LO = 7;
   localparam int OFS_HI = 6;

   localparam logic [2:0] OP_AND = 3'h0;
   localparam logic [2:0] OP_ADD = 3'h1;
   localparam logic [2:0] OP_INC_SKIP = 3'h2;
   localparam logic [2:0] OP_DEPOSIT = 3'h3;
   localparam logic [2:0] OP_CALL = 3'h4;
   localparam logic [2:0] OP_JUMP = 3'h5;
   localparam logic [2:0] OP_XFER = 3'h6;
   localparam logic [2:0] OP_OPERATE = 3'h7;

   localparam logic [4:0] PAGE_ZERO = 5'h00;
   localparam tis_word_t WORD_ZERO = 12'h000;
   localparam tis_word_t WORD_ONE = 12'h001;
   localparam tis_word_t WORD_ONES = 12'hFFF;
   localparam tis_word_t AUTO_LO = 12'h008;
   localparam tis_word_t AUTO_HI = 12'h00F;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 50;
   localparam int TS_MIN_NS = 250;
   localparam int TS_CYC = (TS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TS_CYC - 1);
   localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
   localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;

   typedef enum logic [2:0] {
      TSTATE1 = 3'b001,
      TSTATE2 = 3'b010,
      TSTATE3 = 3'b011,
      TSTATE4 = 3'b100,
      TSTATE5 = 3'b101
   } tis_tstate_t;

   typedef enum logic [1:0] {
      MJ_FETCH = 2'b00,
      MJ_DEFER = 2'b01,
      MJ_EXEC = 2'b10
   } tis_major_t;
endpackage

// ==== logic/tis_tim_if.sv ====
`timescale 1ns/10ps
interface tis_tim_if;
   import tis_pkg::*;
   tis_tstate_t ts;
   logic tp;
   logic run;
   logic mem_wait;
   logic strobe_seen;
   modport timer (output ts, output tp, input run, input mem_wait, input strobe_seen);
   modport seq (input ts, input tp, output run, output mem_wait, output strobe_seen);
endinterface

// ==== logic/tis_timer.sv ====
`timescale 1ns/10ps
module tis_timer
   import tis_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Sequencer side
   tis_tim_if.timer tif
);
   logic [DIV_W-1:0] cnt_ff;
   logic tp_ff;
   tis_tstate_t ts_ff;
   tis_tstate_t nxt_ts;
   logic tick;
   logic go;

   // ----------------------------------------
   // Pacing
   // ----------------------------------------
   assign tick = (cnt_ff == DIV_LAST);
   // A stopped machine parks in state 1; state 2 holds until memory answers
   assign go = tick && !tp_ff && (ts_ff != TSTATE1 || tif.run)
      && (ts_ff != TSTATE2 || !tif.mem_wait || tif.strobe_seen);
   always_comb begin
      case (ts_ff)
         TSTATE1: nxt_ts = TSTATE2;
         TSTATE2: nxt_ts = TSTATE3;
         TSTATE3: nxt_ts = TSTATE4;
         TSTATE4: nxt_ts = TSTATE5;
         TSTATE5: nxt_ts = TSTATE1;
         default: nxt_ts = TSTATE1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= DIV_ZERO;
         tp_ff <= 1'b0;
         ts_ff <= TSTATE1;
      end else begin
         cnt_ff <= tick ? DIV_ZERO : cnt_ff + DIV_ONE;
         tp_ff <= go;
         // Pulse is seen while the ending state is still shown
         if (tp_ff) begin
            ts_ff <= nxt_ts;
         end
      end
   end

   assign tif.tp = tp_ff;
   assign tif.ts = ts_ff;
endmodule // tis_timer

// ==== logic/tis_seq.sv ====
`timescale 1ns/10ps
module tis_seq
   import tis_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Console
   input wire logic exec_switch,
   input wire logic [11:0] left_switch_word,
   input wire logic run_enable,
   input wire logic native_mode,
   // Memory
   input wire logic mem_strobe,
   input wire logic [11:0] mem_rdata,
   output logic [11:0] mem_addr,
   output logic [11:0] mem_wdata,
   output logic mem_read,
   output logic mem_write,
   // Processor state
   output logic [11:0] accumulator,
   output logic link,
   output logic [11:0] program_counter,
   output logic [11:0] instruction_reg,
   output logic [1:0] major_state,
   output logic skip_flag
);
   localparam int SYNC_W = 28;

   // ----------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------
   logic rst1_ff;
   logic rst2_ff;
   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic do_s;
   logic run_s;
   logic mode_s;
   logic strobe_s;
   tis_word_t switch_s;
   tis_word_t mem_s;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst1_ff <= 1'b0;
         rst2_ff <= 1'b0;
      end else begin
         rst1_ff <= 1'b1;
         rst2_ff <= rst1_ff;
      end
   end

   always_ff @(posedge clk or negedge rst2_ff) begin
      if (!rst2_ff) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= {exec_switch, run_enable, native_mode, mem_strobe,
            left_switch_word, mem_rdata};
         sync2_ff <= sync1_ff;
      end
   end

   assign do_s = sync2_ff[27];
   assign run_s = sync2_ff[26];
   assign mode_s = sync2_ff[25];
   assign strobe_s = sync2_ff[24];
   assign switch_s = sync2_ff[23:12];
   assign mem_s = sync2_ff[11:0];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   tis_word_t prog_ff;
   tis_word_t addr_ff;
   tis_word_t buf_ff;
   tis_word_t instr_ff;
   tis_word_t acc_ff;
   logic link_ff;
   logic skip_ff;
   logic skip_aux_ff;
   tis_major_t major_ff;
   tis_major_t next_major_ff;
   logic from_defer_ff;
   logic mem_rd_ff;
   logic mem_wr_ff;
   logic strobe_d_ff;
   logic strobe_seen_ff;

   // ----------------------------------------
   // Timing generator
   // ----------------------------------------
   tis_tim_if tif ();
   tis_timer u_timer (
      .clk(clk),
      .rst_n(rst2_ff),
      .tif(tif)
   );

   logic pulse1;
   logic pulse2;
   logic pulse3;
   logic pulse4;
   logic pulse5;
   logic in_fetch;
   logic in_defer;
   logic in_exec;
   logic need_mem;
   logic strobe_rise;

   assign pulse1 = tif.tp && (tif.ts == TSTATE1);
   assign pulse2 = tif.tp && (tif.ts == TSTATE2);
   assign pulse3 = tif.tp && (tif.ts == TSTATE3);
   assign pulse4 = tif.tp && (tif.ts == TSTATE4);
   assign pulse5 = tif.tp && (tif.ts == TSTATE5);
   assign in_fetch = (major_ff == MJ_FETCH);
   assign in_defer = (major_ff == MJ_DEFER);
   assign in_exec = (major_ff == MJ_EXEC);
   // Switch-driven fetch needs no core cycle, so it must not wait on a strobe
   assign need_mem = !(in_fetch && do_s);
   assign strobe_rise = strobe_s && !strobe_d_ff;
   assign tif.run = run_s;
   assign tif.mem_wait = need_mem;
   assign tif.strobe_seen = strobe_seen_ff;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic [2:0] opc;
   logic is_memref;
   logic is_operate;
   logic is_xfer;
   logic is_jump;
   logic is_operate1;
   logic direct_jump;
   logic auto_idx;
   tis_word_t page_addr;
   tis_word_t prog_inc;
   tis_word_t addr_inc;
   logic [12:0] mem_inc;
   logic [12:0] add_sum;

   assign opc = instr_ff[OPC_HI:OPC_LO];
   assign is_memref = mode_s && (opc <= OP_JUMP);
   assign is_operate = mode_s && (opc == OP_OPERATE);
   assign is_xfer = mode_s && (opc == OP_XFER);
   assign is_jump = is_memref && (opc == OP_JUMP);
   assign is_operate1 = is_operate && !instr_ff[B03];
   assign direct_jump = is_jump && !instr_ff[B03];
   assign page_addr = buf_ff[B04] ? {addr_ff[PAGE_HI:PAGE_LO], buf_ff[OFS_HI:0]}
      : {PAGE_ZERO, buf_ff[OFS_HI:0]};
   assign auto_idx = (addr_ff >= AUTO_LO) && (addr_ff <= AUTO_HI);
   assign prog_inc = prog_ff + WORD_ONE;
   assign addr_inc = addr_ff + WORD_ONE;
   assign mem_inc = {1'b0, mem_s} + {1'b0, WORD_ONE};
   assign add_sum = {1'b0, acc_ff} + {1'b0, buf_ff};

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   tis_word_t nxt_addr;
   tis_word_t nxt_prog;
   tis_word_t nxt_buf;
   tis_word_t nxt_acc;
   tis_word_t op1_acc;
   logic nxt_link;
   logic op1_link;
   tis_major_t nxt_major;
   logic prog_load;
   logic acc_load;
   logic link_load;

   assign nxt_addr = in_fetch ? (skip_ff ? prog_inc : prog_ff)
      : (in_defer ? page_addr
      : (from_defer_ff ? buf_ff : page_addr));

   assign prog_load = (in_fetch && pulse1 && skip_ff)
      || (in_fetch && pulse2 && !do_s)
      || (in_fetch && pulse4 && direct_jump)
      || (in_defer && pulse4 && is_jump)
      || (in_exec && pulse4 && opc == OP_CALL);
   assign nxt_prog = (in_fetch && pulse4) ? page_addr
      : (in_defer ? buf_ff
      : (in_exec ? addr_inc : prog_inc));

   assign nxt_buf = in_fetch ? (do_s ? switch_s : mem_s)
      : (in_defer ? (auto_idx ? mem_inc[11:0] : mem_s)
      : (opc == OP_INC_SKIP ? mem_inc[11:0]
      : (opc == OP_DEPOSIT ? acc_ff
      : (opc == OP_CALL ? prog_ff : mem_s))));

   always_comb begin
      case ({buf_ff[B04], buf_ff[B06]})
         2'b00: op1_acc = acc_ff;
         2'b01: op1_acc = ~acc_ff;
         2'b10: op1_acc = WORD_ZERO;
         2'b11: op1_acc = WORD_ONES;
         default: op1_acc = acc_ff;
      endcase
      case ({buf_ff[B05], buf_ff[B07]})
         2'b00: op1_link = link_ff;
         2'b01: op1_link = ~link_ff;
         2'b10: op1_link = 1'b0;
         2'b11: op1_link = 1'b1;
         default: op1_link = link_ff;
      endcase
   end

   assign acc_load = (in_fetch && pulse4 && is_operate1)
      || (in_exec && pulse4 && (opc == OP_AND || opc == OP_ADD || opc == OP_DEPOSIT))
      || (in_exec && pulse5 && opc == OP_AND);
   assign nxt_acc = in_fetch ? op1_acc
      : (pulse5 ? ~acc_ff
      : (opc == OP_AND ? (~acc_ff | ~buf_ff)
      : (opc == OP_ADD ? add_sum[11:0] : WORD_ZERO)));
   assign link_load = (in_fetch && pulse4 && is_operate1)
      || (in_exec && pulse4 && opc == OP_ADD);
   assign nxt_link = in_fetch ? op1_link : (link_ff ^ add_sum[12]);

   // Operate, transfer and direct jump finish inside fetch
   assign nxt_major = in_fetch ? ((is_operate || is_xfer || direct_jump) ? MJ_FETCH
      : (instr_ff[B03] ? MJ_DEFER : MJ_EXEC))
      : (in_defer ? (is_jump ? MJ_FETCH : MJ_EXEC) : MJ_FETCH);

   // ----------------------------------------
   // Datapath registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst2_ff) begin
      if (!rst2_ff) begin
         addr_ff <= WORD_ZERO;
         prog_ff <= WORD_ZERO;
         buf_ff <= WORD_ZERO;
      end else begin
         if (pulse1) begin
            addr_ff <= nxt_addr;
         end
         if (prog_load) begin
            prog_ff <= nxt_prog;
         end
         if (pulse3) begin
            buf_ff <= nxt_buf;
         end
      end
   end

   always_ff @(posedge clk or negedge rst2_ff) begin
      if (!rst2_ff) begin
         instr_ff <= WORD_ZERO;
         acc_ff <= WORD_ZERO;
         link_ff <= 1'b0;
      end else begin
         if (in_fetch && pulse2 && !do_s) begin
            instr_ff <= WORD_ZERO;
         end else if (in_fetch && pulse3) begin
            instr_ff <= do_s ? switch_s : mem_s;
         end
         if (acc_load) begin
            acc_ff <= nxt_acc;
         end
         if (link_load) begin
            link_ff <= nxt_link;
         end
      end
   end

   // ----------------------------------------
   // Flags and major state
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst2_ff) begin
      if (!rst2_ff) begin
         skip_ff <= 1'b0;
         skip_aux_ff <= 1'b0;
         major_ff <= MJ_FETCH;
         next_major_ff <= MJ_FETCH;
         from_defer_ff <= 1'b0;
      end else begin
         if (in_exec && pulse3 && opc == OP_INC_SKIP && mem_inc[12]) begin
            skip_ff <= 1'b1;
         end else if (in_fetch && pulse3) begin
            skip_ff <= 1'b0;
         end
         if (in_fetch && pulse3) begin
            skip_aux_ff <= 1'b0;
         end
         if (pulse4) begin
            next_major_ff <= nxt_major;
         end
         if (pulse5) begin
            major_ff <= next_major_ff;
            from_defer_ff <= in_defer;
         end
      end
   end

   // ----------------------------------------
   // Memory handshake
   // ----------------------------------------
   // Core reads are destructive, so every read cycle writes the buffer back
   always_ff @(posedge clk or negedge rst2_ff) begin
      if (!rst2_ff) begin
         mem_rd_ff <= 1'b0;
         mem_wr_ff <= 1'b0;
         strobe_d_ff <= 1'b0;
         strobe_seen_ff <= 1'b0;
      end else begin
         mem_rd_ff <= pulse1 && need_mem;
         mem_wr_ff <= pulse5 && need_mem;
         strobe_d_ff <= strobe_s;
         if (strobe_rise) begin
            strobe_seen_ff <= 1'b1;
         end else if (pulse1) begin
            strobe_seen_ff <= 1'b0;
         end
      end
   end

   assign mem_addr = addr_ff;
   assign mem_wdata = buf_ff;
   assign mem_read = mem_rd_ff;
   assign mem_write = mem_wr_ff;
   assign accumulator = acc_ff;
   assign link = link_ff;
   assign program_counter = prog_ff;
   assign instruction_reg = instr_ff;
   assign major_state = major_ff;
   assign skip_flag = skip_ff;
endmodule // tis_seq

// ==== sim/tis_seq_asserts.sv ====
`timescale 1ns/10ps
module tis_seq_asserts
   import tis_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Watched ports
   input wire logic [11:0] left_switch_word,
   input wire logic mem_strobe,
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic [11:0] mem_addr,
   input wire logic [11:0] mem_wdata,
   input wire logic [11:0] accumulator,
   input wire logic [11:0] program_counter,
   input wire logic [11:0] instruction_reg,
   input wire logic [1:0] major_state,
   input wire logic skip_flag
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ----
   // Helpers
   // ----
   // Raw strobe, not synced: looser, but never early
   logic strobe_seen_ff;
   wire nxt_strobe_seen = !mem_read && (mem_strobe || strobe_seen_ff);
   wire [2:0] opc = instruction_reg[OPC_HI:OPC_LO];
   wire page_step = major_state == MJ_DEFER || (major_state == MJ_EXEC && !instruction_reg[B03]);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strobe_seen_ff <= 1'h0;
      end else begin
         strobe_seen_ff <= nxt_strobe_seen;
      end
   end
   sequence s_one_read;
      mem_read ##1 !mem_read;
   endsequence
   // ----
   // Assertions
   // ----
   a_count_advance: assert property (
      major_state == MJ_FETCH && $changed(program_counter) && instruction_reg == WORD_ZERO
      |-> program_counter == 12'($past(program_counter) + 12'h001))
      else $error("program counter moved by other than one");
   a_fetch_load: assert property (
      major_state == MJ_FETCH && $changed(instruction_reg) && instruction_reg != WORD_ZERO
      |-> instruction_reg == mem_wdata && !skip_flag)
      else $error("instruction and buffer differ after load");
   a_strobe_first: assert property (
      major_state == MJ_FETCH && $changed(instruction_reg) && instruction_reg != WORD_ZERO
      |-> strobe_seen_ff || instruction_reg == left_switch_word)
      else $error("instruction loaded before memory strobe");
   a_defer_entry: assert property (
      $past(major_state) == MJ_FETCH && major_state == MJ_DEFER
      |-> instruction_reg[B03] && opc != OP_OPERATE)
      else $error("defer entered wrongly");
   a_exec_entry: assert property (
      $past(major_state) == MJ_FETCH && major_state == MJ_EXEC
      |-> !instruction_reg[B03] && opc < OP_JUMP)
      else $error("execute entered wrongly");
   a_operate_stays: assert property (
      major_state != MJ_FETCH |-> opc != OP_OPERATE)
      else $error("operate left the fetch cycle");
   a_defer_jump: assert property (
      $past(major_state) == MJ_DEFER && major_state == MJ_FETCH |-> program_counter == mem_wdata)
      else $error("jump target not taken from buffer");
   a_page_addr: assert property (
      page_step && $changed(mem_addr) |-> mem_addr[6:0] == instruction_reg[6:0]
      && (instruction_reg[B04] ? ((mem_addr ^ $past(mem_addr)) >> 7) == WORD_ZERO
      : mem_addr[11:7] == PAGE_ZERO))
      else $error("operand page formed wrongly");
   a_pointer_addr: assert property (
      major_state == MJ_EXEC && instruction_reg[B03] && $changed(mem_addr) |-> mem_addr == mem_wdata)
      else $error("pointer not moved to address");
   a_exec_read: assert property (
      major_state == MJ_EXEC && $changed(mem_addr) |-> ##[0:2] s_one_read)
      else $error("execute did not read memory");
   a_deposit_clear: assert property (
      $past(major_state) == MJ_EXEC && major_state == MJ_FETCH && opc == OP_DEPOSIT
      |-> accumulator == WORD_ZERO ##[0:2] mem_write)
      else $error("deposit left accumulator set");
endmodule // tis_seq_asserts

bind tis_seq tis_seq_asserts u_tis_seq_asserts (
   .clk(clk), .reset_n(reset_n), .left_switch_word(left_switch_word),
   .mem_strobe(mem_strobe), .mem_read(mem_read), .mem_write(mem_write),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .accumulator(accumulator),
   .program_counter(program_counter), .instruction_reg(instruction_reg),
   .major_state(major_state), .skip_flag(skip_flag)
);

// ==== sim/tis_mem_model.sv ====
`timescale 1ns/10ps
module tis_mem_model (
   // Clock and pacing
   input wire logic clk,
   input wire logic slow,
   // Core control
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic [11:0] mem_addr,
   input wire logic [11:0] mem_wdata,
   output logic mem_strobe,
   output logic [11:0] mem_rdata
);
   logic [11:0] mem [0:4095];
   logic [11:0] addr;
   always @(posedge clk) begin
      if (mem_write === 1'h1) begin
         mem[mem_addr] = mem_wdata;
      end
   end
   // Stale data is inverted, so an early sample cannot match by luck
   initial begin
      mem_strobe = 1'h0;
      mem_rdata = 12'h000;
      forever begin
         @(posedge clk);
         if (mem_read === 1'h1) begin
            addr = mem_addr;
            #1 mem_rdata = ~mem_rdata;
            repeat (slow ? 6 : 1) @(posedge clk);
            #1 mem_rdata = mem[addr];
            mem_strobe = 1'h1;
            @(posedge clk);
            #1 mem_strobe = 1'h0;
         end
      end
   end
endmodule // tis_mem_model

// ==== sim/test_twelve_bit_instruction_sequencer.sv ====
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("unexpected %s: expected %h, seen %h", what, exp, got); \
      end \
   end
module test_twelve_bit_instruction_sequencer;
   import tis_pkg::*;
   logic clk, reset_n, exec_switch, run_enable, native_mode, slow;
   logic mem_strobe, mem_read, mem_write, link, skip_flag;
   logic [1:0] major_state;
   tis_word_t left_switch_word, mem_rdata, mem_addr, mem_wdata;
   tis_word_t accumulator, program_counter, instruction_reg;
   int mismatches, comparisons;
   // Program image, then addresses and results seen at each fetch
   tis_word_t pa [25] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
      12'h007, 12'h008, 12'h009, 12'h041, 12'h085, 12'h086, 12'h087, 12'h088, 12'h020,
      12'h021, 12'h023, 12'h024, 12'h00A, 12'h030, 12'h025, 12'h090, 12'h091, 12'h031};
   tis_word_t pd [25] = '{12'hEF0, 12'h020, 12'h221, 12'h622, 12'h423, 12'hE20, 12'h424,
      12'h30A, 12'h840, 12'hB25, 12'hB40, 12'h290, 12'h391, 12'hC00, 12'hA88, 12'h5A3,
      12'hA5E, 12'hFFF, 12'h010, 12'h02F, 12'h0F0, 12'h085, 12'h100, 12'h031, 12'h001};
   tis_word_t sa [13] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h006, 12'h007, 12'h008,
      12'h041, 12'h009, 12'h085, 12'h086, 12'h087, 12'h088};
   tis_word_t sac [13] = '{12'hFFF, 12'h5A3, 12'h001, 12'h000, 12'h000, 12'h000, 12'h0F0,
      12'h0F0, 12'h0F0, 12'h0F0, 12'h1F0, 12'h1F1, 12'h1F1};
   logic sl [13] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
      1'h0, 1'h0};
   tis_word_t wa [5] = '{12'h022, 12'h023, 12'h024, 12'h00A, 12'h040};
   tis_word_t mv [5] = '{12'h001, 12'h000, 12'h011, 12'h030, 12'h009};

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   tis_seq u_tis_seq (.clk(clk), .reset_n(reset_n), .exec_switch(exec_switch),
      .left_switch_word(left_switch_word), .run_enable(run_enable),
      .native_mode(native_mode), .mem_strobe(mem_strobe), .mem_rdata(mem_rdata),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_read(mem_read),
      .mem_write(mem_write), .accumulator(accumulator), .link(link),
      .program_counter(program_counter), .instruction_reg(instruction_reg),
      .major_state(major_state), .skip_flag(skip_flag));
   tis_mem_model u_tis_mem_model (.clk(clk), .slow(slow), .mem_read(mem_read),
      .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_strobe(mem_strobe), .mem_rdata(mem_rdata));

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Bounded wait for the read pulse that fetches addr
   task automatic step_to(input tis_word_t addr);
      int n;
      n = 0;
      while (!(mem_read === 1'h1 && major_state === MJ_FETCH && mem_addr === addr)) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 400) begin
            mismatches++;
            $display("unexpected fetch address: expected %h, seen %h", addr, mem_addr);
            final_report();
         end
      end
   endtask

   // Bounded wait for a register value, sel high watches the accumulator
   task automatic wait_for(input logic sel, input tis_word_t want);
      int n;
      n = 0;
      while ((sel ? accumulator : instruction_reg) !== want) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 400) begin
            mismatches++;
            $display("unexpected wait value: expected %h, seen %h", want,
               sel ? accumulator : instruction_reg);
            final_report();
         end
      end
   endtask

   initial begin
      reset_n = 1'h0;
      exec_switch = 1'h0;
      left_switch_word = 12'h000;
      run_enable = 1'h0;
      native_mode = 1'h1;
      slow = 1'h0;
      mismatches = 0;
      comparisons = 0;
      for (int i = 0; i < 4096; i++) u_tis_mem_model.mem[i] = 12'h000;
      for (int i = 0; i < 25; i++) u_tis_mem_model.mem[pa[i]] = pd[i];
      repeat (16) @(posedge clk);
      #1 reset_n = 1'h1;
      run_enable = 1'h1;
      for (int i = 0; i < 13; i++) begin
         slow = i[0];
         step_to(sa[i]);
         `CHK("accumulator", sac[i], accumulator)
         `CHK("link", sl[i], link)
      end
      for (int i = 0; i < 5; i++) begin
         `CHK("memory word", mv[i], u_tis_mem_model.mem[wa[i]])
      end
      $display("test program run done");
      // Park first, so the switch acts on a whole fetch
      run_enable = 1'h0;
      repeat (100) @(posedge clk);
      #1 left_switch_word = 12'hE80;
      exec_switch = 1'h1;
      repeat (10) @(posedge clk);
      #1 run_enable = 1'h1;
      wait_for(1'b0, 12'hE80);
      wait_for(1'b1, 12'h000);
      `CHK("program counter", 12'h088, program_counter)
      `CHK("memory buffer", 12'hE80, mem_wdata)
      `CHK("accumulator", 12'h000, accumulator)
      $display("test switch run done");
      final_report();
   end
endmodule // test_twelve_bit_instruction_sequencer
